//--- hw/flash_host.sv
/*
 * Host-side controller for an asynchronous parallel NOR flash: read,
 * command write, hardware reset pulse and accelerated program level.
 * Assumes the flash pins are wired directly; data lines are three signals.
 */
`timescale 1ns/1ps

// Contract
// - Read: chip select, gate low, strobe high
// - Write: strobe, select low, gate high
// - Short program mode: two writes per byte; code issues one bus write per request
// - High voltage only during accelerated programming; code drives it from accel_i in idle and during writes
// - Wait full access time after standby
// - Restart aborted operation after reset; code only returns to idle for the user to reissue it
// - Wait recovery delay before read
// - 23-bit address, top seven bits sector
module flash_host (
    // Clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           reset_i,
    // User request
    input  wire logic                           req_valid_i,
    input  wire flash_host_pkg::req_s           req_i,
    input  wire logic                           accel_i,
    output logic                                req_ready_o,
    output logic                                rdata_valid_o,
    output logic [flash_host_pkg::DATA_W-1:0]   rdata_o,
    output logic                                busy_o,
    // Flash pins
    output flash_host_pkg::pins_s               pins_o,
    output logic [flash_host_pkg::DATA_W-1:0]   data_out_o,
    output logic                                data_oe_o,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_in_i,
    input  wire logic                           ready_busy_n_i
);
    // ==========================================================
    // State
    typedef enum logic [2:0] {
        S_IDLE, S_READ, S_WR_LOW, S_WR_HIGH, S_RST_LOW, S_RST_WAIT, S_RECOVER
    } state_e;

    state_e                               state_r, state_nxt;
    logic [flash_host_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;
    flash_host_pkg::pins_s                pins_r, pins_nxt;
    logic [flash_host_pkg::DATA_W-1:0]    dout_r, dout_nxt;
    logic                                 doe_r, doe_nxt;
    logic [flash_host_pkg::DATA_W-1:0]    rdata_r, rdata_nxt;
    logic                                 rvalid_r, rvalid_nxt;
    logic                                 ready_r, ready_nxt;
    logic                                 busy_r, busy_nxt;
    logic [1:0]                           rb_sync_r;
    logic [flash_host_pkg::DATA_W-1:0]    din_s1_r, din_s2_r;

    // Count load helper
    function automatic logic [flash_host_pkg::CNT_W-1:0] cyc(input int n);
        cyc = flash_host_pkg::CNT_W'(n);
    endfunction

    // Pin input synchronisers
    always_ff @(posedge clk_i) begin
        rb_sync_r <= {rb_sync_r[0], ready_busy_n_i};
        din_s1_r  <= data_in_i;
        din_s2_r  <= din_s1_r;
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        pins_nxt   = pins_r;
        dout_nxt   = dout_r;
        doe_nxt    = doe_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        ready_nxt  = 1'b0;
        if (cnt_r != '0) begin
            cnt_nxt = cnt_r - flash_host_pkg::CNT_ONE;
        end
        unique case (state_r)
            S_IDLE: begin
                // Standby: select high, reset high, bus released
                pins_nxt.chip_sel_n = 1'b1;
                pins_nxt.out_gate_n = 1'b1;
                pins_nxt.write_n    = 1'b1;
                pins_nxt.reset_n    = 1'b1;
                pins_nxt.fast_program_pin = accel_i;
                doe_nxt   = 1'b0;
                ready_nxt = 1'b1;
                if (req_valid_i && ready_r) begin
                    ready_nxt     = 1'b0;
                    pins_nxt.addr = req_i.addr;
                    unique case (req_i.op)
                        flash_host_pkg::OP_READ: begin
                            pins_nxt.chip_sel_n = 1'b0;
                            pins_nxt.out_gate_n = 1'b0;
                            pins_nxt.fast_program_pin = 1'b0;
                            cnt_nxt   = cyc(flash_host_pkg::ACCESS_CYC + flash_host_pkg::SYNC_CYC);
                            state_nxt = S_READ;
                        end
                        flash_host_pkg::OP_WRITE: begin
                            // One bus write per request; short mode needs two
                            pins_nxt.chip_sel_n = 1'b0;
                            pins_nxt.write_n    = 1'b0;
                            dout_nxt  = req_i.wdata;
                            doe_nxt   = 1'b1;
                            cnt_nxt   = cyc(flash_host_pkg::WRITE_PULSE_CYC);
                            state_nxt = S_WR_LOW;
                        end
                        flash_host_pkg::OP_RESET: begin
                            pins_nxt.reset_n = 1'b0;
                            pins_nxt.fast_program_pin = 1'b0;
                            cnt_nxt   = cyc(flash_host_pkg::RESET_PULSE_CYC);
                            state_nxt = S_RST_LOW;
                        end
                        default: begin
                            ready_nxt = 1'b1;
                        end
                    endcase
                end
            end
            S_READ: begin
                if (cnt_r == '0) begin
                    rdata_nxt  = din_s2_r;
                    rvalid_nxt = 1'b1;
                    pins_nxt.chip_sel_n = 1'b1;
                    pins_nxt.out_gate_n = 1'b1;
                    state_nxt  = S_IDLE;
                end
            end
            S_WR_LOW: begin
                if (cnt_r == '0) begin
                    pins_nxt.write_n    = 1'b1;
                    pins_nxt.chip_sel_n = 1'b1;
                    cnt_nxt   = cyc(flash_host_pkg::WRITE_HIGH_CYC);
                    state_nxt = S_WR_HIGH;
                end
            end
            S_WR_HIGH: begin
                doe_nxt = 1'b0;
                if (cnt_r == '0) begin
                    state_nxt = S_IDLE;
                end
            end
            S_RST_LOW: begin
                if (cnt_r == '0) begin
                    pins_nxt.reset_n = 1'b1;
                    state_nxt = S_RST_WAIT;
                end
            end
            S_RST_WAIT: begin
                // Wait for busy to clear after reset
                if (rb_sync_r[1]) begin
                    cnt_nxt   = cyc(flash_host_pkg::RESET_READ_CYC);
                    state_nxt = S_RECOVER;
                end
            end
            S_RECOVER: begin
                // Back to idle so the user can reissue an aborted job
                if (cnt_r == '0) begin
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != S_IDLE);
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r  <= S_IDLE;
            cnt_r    <= '0;
            pins_r   <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1,
                          reset_n: 1'b1, fast_program_pin: 1'b0, addr: '0};
            dout_r   <= '0;
            doe_r    <= 1'b0;
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
            ready_r  <= 1'b0;
            busy_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            pins_r   <= pins_nxt;
            dout_r   <= dout_nxt;
            doe_r    <= doe_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            ready_r  <= ready_nxt;
            busy_r   <= busy_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign pins_o        = pins_r;
    assign data_out_o    = dout_r;
    assign data_oe_o     = doe_r;
    assign rdata_o       = rdata_r;
    assign rdata_valid_o = rvalid_r;
    assign req_ready_o   = ready_r;
    assign busy_o        = busy_r;

    // ==========================================================
    // Assertions
    a_read_pin_levels: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_r == S_READ) |-> (!pins_r.chip_sel_n && !pins_r.out_gate_n && pins_r.write_n))
        else $error("read cycle pin levels wrong");
    a_write_pin_levels: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_r == S_WR_LOW) |-> (!pins_r.chip_sel_n && pins_r.out_gate_n && !pins_r.write_n))
        else $error("write cycle pin levels wrong");
    a_read_access_wait: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_r == S_IDLE && $past(state_r) == S_IDLE && state_nxt == S_READ)
        |=> (state_r == S_READ)[*5])
        else $error("read sampled before access time");
    a_reset_pulse_width: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(pins_r.reset_n) |-> !pins_r.reset_n[*8])
        else $error("reset pulse too short");
    a_idle_standby: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_r == S_IDLE && $past(state_r) == S_IDLE) |-> (pins_r.chip_sel_n && pins_r.reset_n && !doe_r))
        else $error("idle not in standby");
    a_accel_not_reset: assert property (@(posedge clk_i) disable iff (reset_i)
        !pins_r.reset_n |-> !pins_r.fast_program_pin)
        else $error("fast program level during reset");
    a_accel_read_low: assert property (@(posedge clk_i) disable iff (reset_i)
        !pins_r.out_gate_n |-> !pins_r.fast_program_pin)
        else $error("fast program level during read");
    a_recover_busy: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_r == S_RST_WAIT && !rb_sync_r[1]) |=> (state_r == S_RST_WAIT))
        else $error("left reset wait while busy");
    a_recover_delay: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_r == S_RST_WAIT && rb_sync_r[1]) |=> (state_r == S_RECOVER)[*3])
        else $error("read allowed before recovery delay");
    c_read: cover property (@(posedge clk_i) rvalid_r);
    c_write: cover property (@(posedge clk_i) state_r == S_WR_HIGH);
    c_reset: cover property (@(posedge clk_i) state_r == S_RECOVER);
    c_accel: cover property (@(posedge clk_i) pins_r.fast_program_pin && !pins_r.write_n);
endmodule

//--- hw/flash_host_pkg.sv
/*
 * Constants and carriers for the parallel NOR flash bus controller.
 * Assumes a 50 MHz single clock; timing figures are plain defaults.
 */
package flash_host_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 23;
    localparam int DATA_W = 8;
    localparam int SECT_LSB = 16;
    localparam int SECT_W = 7;
    // ==========================================================
    // Timing in ns, clock period in ns
    localparam int CLK_NS = 20;
    localparam int ACCESS_NS = 90;          // Address/chip-select access time
    localparam int WRITE_PULSE_NS = 35;     // Strobe low width
    localparam int WRITE_HIGH_NS = 30;      // Strobe high between cycles
    localparam int RESET_PULSE_NS = 500;    // reset_pulse_min
    localparam int RESET_READ_NS = 50;      // reset_to_read_delay
    // Counts: least times round up
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_READ_CYC = (RESET_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    localparam int SYNC_CYC = 2;            // Two-flop input synchroniser latency
    // ==========================================================
    // Request kinds
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_RESET
    } op_e;
    // Request from user
    typedef struct packed {
        op_e                      op;
        logic [ADDR_W-1:0]        addr;
        logic [DATA_W-1:0]        wdata;
    } req_s;
    // Pins to flash
    typedef struct packed {
        logic                     chip_sel_n;
        logic                     out_gate_n;
        logic                     write_n;
        logic                     reset_n;
        logic                     fast_program_pin;
        logic [ADDR_W-1:0]        addr;
    } pins_s;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
endpackage

//--- test/flash_model.sv
/* Behavioural parallel NOR flash as seen from its pins.
   Assumes the bench clock times program busy and reset completion. */
`timescale 1ns/1ps
module flash_model #(
    parameter int PROG_CYC = 10,
    parameter int RST_CYC  = 6
) (
    input  wire logic                              clk_i,
    input  wire flash_host_pkg::pins_s             pins_i,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_i,
    input  wire logic                              data_oe_i,
    output logic [flash_host_pkg::DATA_W-1:0]      data_o,
    output logic                                   ready_busy_n_o
);
    logic [7:0] mem [int];
    logic [7:0] last_r = 8'h00;
    int         busy_cnt = 0;
    logic       rd;
    // ==========================================================
    // Read path; released lines show the inverse of the last byte
    assign rd = !pins_i.chip_sel_n && !pins_i.out_gate_n && pins_i.write_n && pins_i.reset_n;
    always @(*) begin
        if (rd)
            data_o = mem.exists(int'(pins_i.addr)) ? mem[int'(pins_i.addr)] : 8'hff;
        else
            data_o = ~last_r;
    end
    assign ready_busy_n_o = (busy_cnt == 0);
    // ==========================================================
    // Writes, busy timing and reset completion
    always @(posedge clk_i) begin
        if (rd)
            last_r <= data_o;
        if (!pins_i.reset_n)
            busy_cnt <= (busy_cnt > 0) ? RST_CYC : 0;
        // Commands are not decoded: erase and code reads stay plain bytes
        else if (!pins_i.chip_sel_n && !pins_i.write_n && pins_i.out_gate_n && data_oe_i) begin
            mem[int'(pins_i.addr)] = data_i;
            busy_cnt <= PROG_CYC;
        end else if (busy_cnt > 0)
            busy_cnt <= busy_cnt - 1;
    end
endmodule

//--- test/tb_flash_host.sv
/* Self-checking bench for the flash host controller.
   Assumes flash_model on the pins and one 50 MHz clock. */
`timescale 1ns/1ps
module tb_flash_host;
    logic clk_i = 0, reset_i = 1, req_valid_i = 0, accel_i = 0;
    flash_host_pkg::req_s req_i = '0;
    logic req_ready_o, rdata_valid_o, busy_o, data_oe_o, ready_busy_n_i;
    logic [7:0] rdata_o, data_out_o, data_in_i;
    flash_host_pkg::pins_s pins_o;
    int num_errors = 0, n_tests = 0, seed = 32'h9f3c_e024;
    logic [7:0] ref_mem [int];
    logic [7:0] exp_q [$];
    // ==========================================================
    // Clock and instances
    always #10 clk_i = ~clk_i;
    flash_host i_flash_host (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .accel_i(accel_i), .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
        .busy_o(busy_o), .pins_o(pins_o), .data_out_o(data_out_o), .data_oe_o(data_oe_o),
        .data_in_i(data_in_i), .ready_busy_n_i(ready_busy_n_i));
    flash_model i_flash_model (.clk_i(clk_i), .pins_i(pins_o), .data_i(data_out_o), .data_oe_i(data_oe_o),
        .data_o(data_in_i), .ready_busy_n_o(ready_busy_n_i));
    // ==========================================================
    // Compare, verdict and request tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic do_req(input flash_host_pkg::op_e op, input logic [22:0] a, input logic [7:0] d);
        int k;
        k = 0;
        req_valid_i <= 1'b1;
        req_i <= '{op, a, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (req_ready_o !== 1'b1 && k < 300);
        req_valid_i <= 1'b0;
        if (k >= 300) begin
            num_errors++;
            print_verdict();
        end
        if (op == flash_host_pkg::OP_READ)
            exp_q.push_back(ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 8'hff);
        if (op == flash_host_pkg::OP_WRITE)
            ref_mem[int'(a)] = d;
        @(posedge clk_i);
    endtask
    // ==========================================================
    // Output watcher
    always @(posedge clk_i) begin
        if (!reset_i) begin
            if (rdata_valid_o === 1'b1)
                check("read data", rdata_o, (exp_q.size() > 0) ? exp_q.pop_front() : 9'h100);
            if (pins_o.out_gate_n === 1'b0)
                check("read pins", {pins_o.write_n, pins_o.fast_program_pin, busy_o}, 3'b101);
            if (req_ready_o === 1'b1)
                check("busy while ready", busy_o, 0);
            if (pins_o.write_n === 1'b0) begin
                check("write pins", {pins_o.out_gate_n, data_oe_o, pins_o.fast_program_pin}, {2'b11, accel_i});
                check("write data", data_out_o, ref_mem[int'(pins_o.addr)]);
            end
            if (pins_o.reset_n === 1'b0)
                check("fast pin in reset", pins_o.fast_program_pin, 0);
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [22:0] a;
        logic [7:0]  d;
        int          k, gap;
        logic        seen_low;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("idle pins", {pins_o.chip_sel_n, pins_o.out_gate_n, pins_o.write_n, pins_o.reset_n}, 4'hf);
        do_req(flash_host_pkg::OP_READ, 23'h00_0000, 8'h00);
        for (int i = 0; i < 8; i++) begin
            a = 23'($random(seed));
            d = 8'($random(seed));
            accel_i <= i[0];
            do_req(flash_host_pkg::OP_WRITE, a, d);
            do_req(flash_host_pkg::OP_READ, a, 8'h00);
        end
        accel_i <= 1'b0;
        do_req(flash_host_pkg::OP_WRITE, 23'h7f_ffff, 8'h5a);
        do_req(flash_host_pkg::OP_RESET, 23'h00_0000, 8'h00);
        k = 0;
        gap = 0;
        seen_low = 1'b0;
        while (req_ready_o !== 1'b1 && k < 300) begin
            @(posedge clk_i);
            k++;
            if (ready_busy_n_i !== 1'b1) begin
                seen_low = 1'b1;
                gap = 0;
            end else
                gap++;
        end
        if (k >= 300) begin
            num_errors++;
            print_verdict();
        end
        check("busy line after reset", ready_busy_n_i, 1);
        check("busy seen in reset", seen_low, 1);
        check("recovery after busy", gap > flash_host_pkg::RESET_READ_CYC, 1);
        do_req(flash_host_pkg::OP_READ, 23'h7f_ffff, 8'h00);
        do_req(flash_host_pkg::OP_WRITE, 23'h7f_ffff, 8'h5a);
        do_req(flash_host_pkg::OP_READ, 23'h7f_ffff, 8'h00);
        do_req(flash_host_pkg::OP_RESET, 23'h00_0000, 8'h00);
        do_req(flash_host_pkg::OP_READ, a, 8'h00);
        repeat (30) @(posedge clk_i);
        check("reads left", exp_q.size(), 0);
        print_verdict();
    end
endmodule
